// ===== sdpp_regs.vh
// register map, field positions and reset values of the data pin port
// and the interrupt level / suspend control; definitions only
`ifndef SDPP_REGS_VH
`define SDPP_REGS_VH

// ************************************************************
// register indices; byte address is four times the index
// ************************************************************
`define SDPP_PORT_CTRL_IDX 16'h704e
`define SDPP_IRQ_SUSP_IDX 16'h704f
`define SDPP_ADDR_W 18
`define SDPP_PORT_CTRL_ADDR {`SDPP_PORT_CTRL_IDX, 2'b00}
`define SDPP_IRQ_SUSP_ADDR {`SDPP_IRQ_SUSP_IDX, 2'b00}

// ************************************************************
// port control fields, per pin nibble: miso low, mosi high
// ************************************************************
`define SDPP_PIN_DIR 0
`define SDPP_PIN_USE 1
`define SDPP_PIN_DRV 2
`define SDPP_PIN_LVL 3
`define SDPP_MISO_BASE 0
`define SDPP_MOSI_BASE 4
`define SDPP_PORT_CTRL_WMASK 8'h77
`define SDPP_PORT_CTRL_RST 8'h00

// ************************************************************
// interrupt level / suspend fields
// ************************************************************
`define SDPP_PRI_BIT 6
`define SDPP_FRZ_BIT 5
`define SDPP_IRQ_SUSP_RST 8'h00

// ************************************************************
// bus answers
// ************************************************************
`define SDPP_RESP_OKAY 2'b00
`define SDPP_RESP_SLVERR 2'b10

`endif

// ===== sdpp_pin_cell.v
// one serial data pin: input synchroniser and registered drive mux
// assumes pin_in is asynchronous to mclk; serial side is on mclk
`timescale 1ns/1ns
module sdpp_pin_cell (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // control bits
   input wire use_serial,
   input wire dir_out,
   input wire drive_val,
   // serial side
   input wire serial_drive,
   input wire serial_en,
   // pin
   input wire pin_in,
   output reg pin_out,
   output reg pin_oe,
   // synchronised level
   output reg level
);

   reg sync1_reg;

   // ************************************************************
   // two stage synchroniser
   // ************************************************************
   always @(posedge mclk) begin
      if (!rst_n) begin
         sync1_reg <= 1'b0;
         level <= 1'b0;
      end else begin
         sync1_reg <= pin_in;
         level <= sync1_reg;
      end
   end

   // ************************************************************
   // drive: serial function or general purpose
   // ************************************************************
   always @(posedge mclk) begin
      if (!rst_n) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else if (use_serial) begin
         pin_out <= serial_drive;
         pin_oe <= serial_en;
      end else begin
         pin_out <= drive_val;
         pin_oe <= dir_out;
      end
   end

endmodule

// ===== sdpp_top.v
// data pin port control and interrupt level / suspend slice of a
// serial peripheral interface, registers on an axi4-lite slave
// assumes: shifter logic on mclk, pins and serial clock pin async
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "sdpp_regs.vh"
module sdpp_top (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // axi4-lite write address
   input wire [17:0] awaddr,
   input wire awvalid,
   output wire awready,
   // axi4-lite write data
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output wire wready,
   // axi4-lite write response
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   // axi4-lite read address
   input wire [17:0] araddr,
   input wire arvalid,
   output wire arready,
   // axi4-lite read data
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   // serial clock pin, sampled
   input wire serial_clock_pin,
   // slave in master out pin
   input wire mosi_pin_in,
   output wire mosi_pin_out,
   output wire mosi_pin_oe,
   // master in slave out pin
   input wire miso_pin_in,
   output wire miso_pin_out,
   output wire miso_pin_oe,
   // shifter data paths
   input wire shift_mosi_drive,
   input wire shift_mosi_en,
   input wire shift_miso_drive,
   input wire shift_miso_en,
   output wire shift_mosi_level,
   output wire shift_miso_level,
   // serial clock edges to shifter
   output reg shift_clk_rise,
   output reg shift_clk_fall,
   // interrupt request routing
   input wire shift_irq_req,
   output reg irq_high_req,
   output reg irq_low_req,
   // emulation suspend
   input wire emu_suspend,
   input wire shift_busy,
   output reg shift_freeze
);

   // ************************************************************
   // registers
   // ************************************************************
   reg [7:0] port_ctrl_reg;
   reg pri_reg;
   reg frz_reg;
   reg aw_held_reg;
   reg w_held_reg;
   reg [17:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg clk_s1_reg;
   reg clk_s2_reg;
   reg clk_s3_reg;
   wire [1:0] pin_level;
   wire [1:0] pin_in_v;
   wire [1:0] pin_out_v;
   wire [1:0] pin_oe_v;
   wire [1:0] ser_drive_v;
   wire [1:0] ser_en_v;
   wire [7:0] port_ctrl_rd;
   wire [7:0] irq_susp_rd;
   wire do_write;
   wire wr_port_ctrl;
   wire wr_irq_susp;
   wire ar_take;
   wire freeze_now;
   reg [7:0] rd_byte;
   reg rd_hit;
   wire [7:0] irq_susp_rst = `SDPP_IRQ_SUSP_RST;

   // ************************************************************
   // axi4-lite handshakes
   // ************************************************************
   assign awready = ~aw_held_reg;
   assign wready = ~w_held_reg;
   assign arready = ~rvalid;
   assign ar_take = arvalid & ~rvalid;
   assign do_write = aw_held_reg & w_held_reg & ~bvalid;
   assign wr_port_ctrl = do_write & w_strb_reg[0] &
      (aw_addr_reg[17:2] == `SDPP_PORT_CTRL_IDX);
   assign wr_irq_susp = do_write & w_strb_reg[0] &
      (aw_addr_reg[17:2] == `SDPP_IRQ_SUSP_IDX);

   always @(posedge mclk) begin
      if (!rst_n) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 18'h0_0000;
      end else if (awvalid && !aw_held_reg) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= awaddr;
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else if (wvalid && !w_held_reg) begin
         w_held_reg <= 1'b1;
         w_data_reg <= wdata;
         w_strb_reg <= wstrb;
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp <= `SDPP_RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         if ((aw_addr_reg[17:2] == `SDPP_PORT_CTRL_IDX) ||
            (aw_addr_reg[17:2] == `SDPP_IRQ_SUSP_IDX)) begin
            bresp <= `SDPP_RESP_OKAY;
         end else begin
            bresp <= `SDPP_RESP_SLVERR;
         end
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ************************************************************
   // register file
   // ************************************************************
   always @(posedge mclk) begin
      if (!rst_n) begin
         port_ctrl_reg <= `SDPP_PORT_CTRL_RST;
      end else if (wr_port_ctrl) begin
         // level bits are not stored
         port_ctrl_reg <= w_data_reg[7:0] & `SDPP_PORT_CTRL_WMASK;
      end
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         pri_reg <= irq_susp_rst[`SDPP_PRI_BIT];
         frz_reg <= irq_susp_rst[`SDPP_FRZ_BIT];
      end else if (wr_irq_susp) begin
         // only two bits stored, the rest dropped
         pri_reg <= w_data_reg[`SDPP_PRI_BIT];
         frz_reg <= w_data_reg[`SDPP_FRZ_BIT];
      end
   end

   // ************************************************************
   // read path
   // ************************************************************
   assign port_ctrl_rd = {pin_level[1], port_ctrl_reg[6:4],
      pin_level[0], port_ctrl_reg[2:0]};
   assign irq_susp_rd = {1'b0, pri_reg, frz_reg, 5'b0_0000};

   always @* begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      case (araddr[17:2])
         `SDPP_PORT_CTRL_IDX: begin
            rd_byte = port_ctrl_rd;
         end
         `SDPP_IRQ_SUSP_IDX: begin
            rd_byte = irq_susp_rd;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `SDPP_RESP_OKAY;
      end else if (ar_take) begin
         rvalid <= 1'b1;
         rdata <= {24'h00_0000, rd_byte};
         rresp <= rd_hit ? `SDPP_RESP_OKAY : `SDPP_RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ************************************************************
   // data pins: index 0 miso, index 1 mosi
   // ************************************************************
   assign pin_in_v = {mosi_pin_in, miso_pin_in};
   assign ser_drive_v = {shift_mosi_drive, shift_miso_drive};
   assign ser_en_v = {shift_mosi_en, shift_miso_en};
   assign mosi_pin_out = pin_out_v[1];
   assign mosi_pin_oe = pin_oe_v[1];
   assign miso_pin_out = pin_out_v[0];
   assign miso_pin_oe = pin_oe_v[0];
   assign shift_mosi_level = pin_level[1];
   assign shift_miso_level = pin_level[0];

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
         // use bit selects serial or gpio; dir only in gpio use
         sdpp_pin_cell u_cell (
            .mclk(mclk),
            .rst_n(rst_n),
            .use_serial(port_ctrl_reg[4 * gi + `SDPP_PIN_USE]),
            .dir_out(port_ctrl_reg[4 * gi + `SDPP_PIN_DIR]),
            .drive_val(port_ctrl_reg[4 * gi + `SDPP_PIN_DRV]),
            .serial_drive(ser_drive_v[gi]),
            .serial_en(ser_en_v[gi]),
            .pin_in(pin_in_v[gi]),
            .pin_out(pin_out_v[gi]),
            .pin_oe(pin_oe_v[gi]),
            .level(pin_level[gi])
         );
      end
   endgenerate

   // ************************************************************
   // emulation suspend
   // ************************************************************
   // freeze bit matters only while suspended; otherwise stop
   // once the current transfer has finished
   assign freeze_now = emu_suspend & (frz_reg | ~shift_busy);

   always @(posedge mclk) begin
      if (!rst_n) begin
         shift_freeze <= 1'b0;
      end else begin
         shift_freeze <= freeze_now;
      end
   end

   // ************************************************************
   // serial clock sampling and edges
   // ************************************************************
   always @(posedge mclk) begin
      if (!rst_n) begin
         clk_s1_reg <= 1'b0;
         clk_s2_reg <= 1'b0;
         clk_s3_reg <= 1'b0;
      end else begin
         clk_s1_reg <= serial_clock_pin;
         clk_s2_reg <= clk_s1_reg;
         clk_s3_reg <= clk_s2_reg;
      end
   end

   // independent of the miso use and direction bits
   always @(posedge mclk) begin
      if (!rst_n) begin
         shift_clk_rise <= 1'b0;
         shift_clk_fall <= 1'b0;
      end else begin
         shift_clk_rise <= clk_s2_reg & ~clk_s3_reg & ~freeze_now;
         shift_clk_fall <= ~clk_s2_reg & clk_s3_reg & ~freeze_now;
      end
   end

   // ************************************************************
   // interrupt level routing
   // ************************************************************
   always @(posedge mclk) begin
      if (!rst_n) begin
         irq_high_req <= 1'b0;
         irq_low_req <= 1'b0;
      end else begin
         irq_high_req <= shift_irq_req & ~pri_reg;
         irq_low_req <= shift_irq_req & pri_reg;
      end
   end

endmodule

// ===== sdpp_asserts.sv
// assertions on the data pin port top level ports
// assumes binding into sdpp_top, all on mclk
`timescale 1ns/1ns
module sdpp_asserts (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // bus
   input wire arvalid,
   input wire arready,
   input wire rvalid,
   input wire rready,
   input wire [31:0] rdata,
   input wire bvalid,
   input wire bready,
   input wire [1:0] bresp,
   // serial side
   input wire serial_clock_pin,
   input wire shift_clk_rise,
   input wire shift_clk_fall,
   input wire miso_pin_in,
   input wire shift_miso_level,
   input wire shift_irq_req,
   input wire irq_high_req,
   input wire irq_low_req,
   input wire emu_suspend,
   input wire shift_busy,
   input wire shift_freeze
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_rise;
      $rose(serial_clock_pin) ##1 !emu_suspend [*3];
   endsequence
   sequence s_up3;
      rst_n [*3];
   endsequence
   a_rise_latency: assert property (s_rise |-> shift_clk_rise)
      else $error("serial clock edge pulse missing");
   a_pulse_single: assert property (shift_clk_rise |->
      !shift_clk_fall ##1 !shift_clk_rise)
      else $error("edge pulse too long");
   a_irq_route: assert property ($past(rst_n) |->
      (irq_high_req | irq_low_req) == $past(shift_irq_req)
      && !(irq_high_req && irq_low_req))
      else $error("interrupt request misrouted");
   a_level_sync: assert property (s_up3 |->
      shift_miso_level == $past(miso_pin_in, 2))
      else $error("pin level not synchronised");
   a_freeze_now: assert property (emu_suspend && !shift_busy |=>
      shift_freeze)
      else $error("no freeze when idle under suspend");
   a_no_suspend: assert property (!emu_suspend |=> !shift_freeze)
      else $error("freeze without suspend");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   a_rdata_hold: assert property (rvalid && !rready |=>
      rvalid && $stable(rdata))
      else $error("read data dropped");
   a_bresp_hold: assert property (bvalid && !bready |=>
      bvalid && $stable(bresp))
      else $error("write response dropped");
endmodule
bind sdpp_top sdpp_asserts sdpp_asserts_i (.*);

// ===== sdpp_pin_load.sv
// far side of the data pins: serial clock source, miso talker
// assumes both data lines are pulled up where nobody drives
`timescale 1ns/1ns
module sdpp_pin_load (
   // design drive
   input wire mosi_out,
   input wire mosi_oe,
   input wire miso_out,
   input wire miso_oe,
   // wire levels
   output logic sclk,
   output wire mosi_w,
   output wire miso_w
);
   logic talk = 1'b0;
   logic bit_v = 1'b0;
   initial sclk = 1'b0;
   assign mosi_w = mosi_oe ? mosi_out : 1'b1;
   assign miso_w = miso_oe ? miso_out : (talk ? bit_v : 1'b1);
   // eight bits, clock idle low outside frames
   task automatic frame(input logic [7:0] tx, input int hp);
      talk = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         bit_v = tx[i];
         #(hp) sclk = 1'b1;
         #(hp) sclk = 1'b0;
      end
      talk = 1'b0;
   endtask
endmodule

// ===== tb.sv
// self-checking bench for the data pin port and suspend slice
// assumes sdpp_top, its checker and the pin load model
`timescale 1ns/1ns
`include "sdpp_regs.vh"
module tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [17:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb, sv;
   logic awvalid, wvalid, bready, arvalid, rready, shift_irq_req;
   logic shift_mosi_drive, shift_mosi_en, shift_miso_drive;
   logic shift_miso_en, emu_suspend, shift_busy;
   logic [7:0] v, lv;
   logic eo, eq, mo, mq;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire serial_clock_pin, mosi_pin_in, miso_pin_in;
   wire mosi_pin_out, mosi_pin_oe, miso_pin_out, miso_pin_oe;
   wire shift_mosi_level, shift_miso_level, shift_clk_rise;
   wire shift_clk_fall, irq_high_req, irq_low_req, shift_freeze;
   int failures = 0;
   int num_checks = 0;
   int seed = 94884;
   int cyc = 0;
   int rises = 0;
   int falls = 0;
   int f0;
   int r0;
   logic [33:0] exp_r[$];
   logic [1:0] exp_b[$];

   sdpp_top sdpp_top_i (.*);
   sdpp_pin_load sdpp_pin_load_i (.mosi_out(mosi_pin_out),
      .mosi_oe(mosi_pin_oe), .miso_out(miso_pin_out),
      .miso_oe(miso_pin_oe), .sclk(serial_clock_pin),
      .mosi_w(mosi_pin_in), .miso_w(miso_pin_in));

   initial forever #10 mclk = ~mclk;

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic axw(input logic [17:0] a, input logic [7:0] d,
         input logic [3:0] s, input logic [1:0] r);
      @(posedge mclk);
      exp_b.push_back(r);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      @(posedge mclk);
      while (!(bvalid === 1'b1 && bready === 1'b1)) begin
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) bready <= 1'b1;
         @(posedge mclk);
      end
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [17:0] a, input logic [1:0] r,
         input logic [7:0] d);
      @(posedge mclk);
      exp_r.push_back({r, 24'h00_0000, d});
      araddr <= a;
      arvalid <= 1'b1;
      @(posedge mclk);
      while (!(rvalid === 1'b1 && rready === 1'b1)) begin
         if (arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) rready <= 1'b1;
         @(posedge mclk);
      end
      rready <= 1'b0;
   endtask

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (shift_clk_rise) rises <= rises + 1;
      if (shift_clk_fall) falls <= falls + 1;
      if (rvalid && rready) chk({rresp, rdata}, exp_r.pop_front());
      if (bvalid && bready) chk(34'(bresp), 34'(exp_b.pop_front()));
      if (cyc == 20000) begin
         failures++;
         report_and_stop();
      end
   end

   initial begin
      {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid,
         rready, shift_mosi_drive, shift_mosi_en, shift_miso_drive,
         shift_miso_en, shift_irq_req, emu_suspend, shift_busy} <= 84'h0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      // let the pin level synchronisers fill
      repeat (2) @(posedge mclk);
      axr(`SDPP_PORT_CTRL_ADDR, `SDPP_RESP_OKAY, 8'h88);
      axr(`SDPP_IRQ_SUSP_ADDR, `SDPP_RESP_OKAY, 8'h00);
      axw(`SDPP_IRQ_SUSP_ADDR, 8'hff, 4'h1, `SDPP_RESP_OKAY);
      axr(`SDPP_IRQ_SUSP_ADDR, `SDPP_RESP_OKAY, 8'h60);
      axw(18'h0_0000, 8'h12, 4'h1, `SDPP_RESP_SLVERR);
      axr(18'h0_0000, `SDPP_RESP_SLVERR, 8'h00);
      for (int i = 0; i < 8; i++) begin
         v = 8'($random(seed)) & 8'h77;
         sv = 4'($random(seed));
         {shift_mosi_drive, shift_mosi_en, shift_miso_drive,
            shift_miso_en} <= sv;
         axw(`SDPP_PORT_CTRL_ADDR, v, 4'h1, `SDPP_RESP_OKAY);
         repeat (3) @(posedge mclk);
         eo = v[1] ? sv[0] : v[0];
         eq = v[1] ? sv[1] : v[2];
         mo = v[5] ? sv[2] : v[4];
         mq = v[5] ? sv[3] : v[6];
         chk(34'(miso_pin_oe), 34'(eo));
         chk(34'(miso_pin_out), 34'(eq));
         chk(34'(mosi_pin_oe), 34'(mo));
         chk(34'(mosi_pin_out), 34'(mq));
         lv = {mo ? mq : 1'b1, v[6:4], eo ? eq : 1'b1, v[2:0]};
         chk(34'(shift_mosi_level), 34'(lv[7]));
         chk(34'(shift_miso_level), 34'(lv[3]));
         axr(`SDPP_PORT_CTRL_ADDR, `SDPP_RESP_OKAY, lv);
      end
      axw(`SDPP_PORT_CTRL_ADDR, 8'h00, 4'h0, `SDPP_RESP_OKAY);
      axr(`SDPP_PORT_CTRL_ADDR, `SDPP_RESP_OKAY, lv);
      for (int p = 0; p < 2; p++) begin
         axw(`SDPP_IRQ_SUSP_ADDR, 8'(p << 6), 4'h1, `SDPP_RESP_OKAY);
         shift_irq_req <= 1'b1;
         repeat (3) @(posedge mclk);
         chk(34'(irq_high_req), 34'(p == 0));
         chk(34'(irq_low_req), 34'(p == 1));
         shift_irq_req <= 1'b0;
      end
      // miso as gpio input, serial clock still counted
      axw(`SDPP_PORT_CTRL_ADDR, 8'h00, 4'h1, `SDPP_RESP_OKAY);
      r0 = rises;
      f0 = falls;
      #7;
      sdpp_pin_load_i.frame(8'ha5, 80);
      sdpp_pin_load_i.frame(8'h3c, 240);
      repeat (6) @(posedge mclk);
      chk(34'(rises - r0), 34'h10);
      chk(34'(falls - f0), 34'h10);
      axw(`SDPP_IRQ_SUSP_ADDR, 8'h00, 4'h1, `SDPP_RESP_OKAY);
      shift_busy <= 1'b1;
      emu_suspend <= 1'b1;
      repeat (3) @(posedge mclk);
      chk(34'(shift_freeze), 34'h0);
      shift_busy <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(34'(shift_freeze), 34'h1);
      emu_suspend <= 1'b0;
      shift_busy <= 1'b1;
      axw(`SDPP_IRQ_SUSP_ADDR, 8'h20, 4'h1, `SDPP_RESP_OKAY);
      chk(34'(shift_freeze), 34'h0);
      emu_suspend <= 1'b1;
      repeat (3) @(posedge mclk);
      chk(34'(shift_freeze), 34'h1);
      // frozen at once: serial clock edges must not reach the shifter
      r0 = rises;
      #7;
      sdpp_pin_load_i.frame(8'h5a, 80);
      repeat (6) @(posedge mclk);
      chk(34'(rises - r0), 34'h0);
      report_and_stop();
   end
endmodule
